// [common/ttc_pkg.sv]
package ttc_pkg;

  // Register indices; the Wishbone byte address is four times the index.
  localparam logic [7:0] TTC_IDX_OSC_CAL = 8'h23;
  localparam logic [7:0] TTC_IDX_PUMP_MIX = 8'h24;
  localparam logic [7:0] TTC_IDX_CONV_SYN = 8'h25;
  localparam logic [7:0] TTC_IDX_COUPLER = 8'h26;
  localparam logic [7:0] TTC_IDX_STAGE = 8'h27;
  localparam logic [7:0] TTC_IDX_CAL_STATUS = 8'h28;

  // Oscillator calibration test register fields.
  localparam int TTC_OSC_HAND_BIT = 7;
  localparam int TTC_OSC_FORCE_BIT = 6;
  localparam int TTC_OSC_VALUE_LSB = 0;

  // Pump and mixer test register fields.
  localparam int TTC_PUMP_OFF_BIT = 7;
  localparam int TTC_PUMP_UP_BIT = 6;
  localparam int TTC_PUMP_DN_BIT = 5;
  localparam int TTC_MIX_POL_LSB = 3;
  localparam int TTC_MIX_EN_BIT = 2;
  localparam int TTC_TM_FILT_BIT = 1;
  localparam int TTC_TM_CONV_BIT = 0;

  // Converter and synthesizer test register fields.
  localparam int TTC_FCOMP_BIT = 7;
  localparam int TTC_DITHER_BIT = 6;
  localparam int TTC_ADC_OUT_BIT = 5;
  localparam int TTC_CHOP_BIT = 4;
  localparam int TTC_SHAPE_BIT = 3;
  localparam int TTC_VCM_BIT = 2;
  localparam int TTC_ROT_LSB = 0;

  // Gain coupler and stage override fields.
  localparam int TTC_VGA_OVR_BIT = 3;
  localparam int TTC_AC1_BIT = 2;
  localparam int TTC_AC2_LSB = 0;
  localparam int TTC_STG1_LSB = 4;
  localparam int TTC_STG2_LSB = 2;
  localparam int TTC_STG3_LSB = 0;

  // Interface register bits that steer the analog test module.
  localparam int TTC_IF_PD_BIT = 3;

  // Writable masks; reserved bits are not stored and read as zero.
  localparam logic [7:0] TTC_COUPLER_MASK = 8'h0F;
  localparam logic [7:0] TTC_STAGE_MASK = 8'h3F;

  // Values after reset.
  localparam logic [7:0] TTC_RST_OSC_CAL = 8'h06;
  localparam logic [7:0] TTC_RST_PUMP_MIX = 8'h00;
  localparam logic [7:0] TTC_RST_CONV_SYN = 8'h40;
  localparam logic [7:0] TTC_RST_COUPLER = 8'h00;
  localparam logic [7:0] TTC_RST_STAGE = 8'h00;

  typedef struct packed {
    logic [5:0] osc_current;
    logic osc_cal_strobe;
    logic pump_normal_off;
    logic pump_force_up;
    logic pump_force_down;
    logic mixer_dc_force_en;
    logic mixer_i_pos;
    logic mixer_q_pos;
    logic testmod_to_filter;
    logic testmod_to_converter;
    logic testmod_powerdown;
    logic [2:0] testmod_mode;
    logic freq_comp_en;
    logic sigma_delta_dither_en;
    logic integrator_chop_off;
    logic mismatch_shaping_off;
    logic common_mode_rotation_off;
    logic [1:0] adc_rotate_pos;
  } ttc_analog_type;

  typedef struct packed {
    logic first_coupler_force;
    logic [1:0] second_coupler_force;
    logic [1:0] gain_stage_one_force;
    logic [1:0] gain_stage_two_force;
    logic [1:0] gain_stage_three_force;
  } ttc_gain_type;

  typedef struct packed {
    logic lock_pin;
    logic serial_data_pin;
    logic serial_data_pin_oe;
    logic serial_clock_pin;
  } ttc_pins_type;

endpackage

// [src/ttc_test_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module ttc_test_bank (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Neighbouring logic and analog sense.
  input wire logic [5:0] osc_current_cal_i,
  input wire logic osc_current_comparator_i,
  input wire logic [3:0] interface_ctrl_i,
  input wire logic adc_sample_i,
  input wire logic adc_sample_clk_i,
  input wire logic adc_step_i,
  input wire logic [8:0] gain_normal_i,
  input wire ttc_pkg::ttc_pins_type pins_normal_i,
  // Analog controls and pins.
  output ttc_pkg::ttc_analog_type analog_o,
  output logic vga_override_o,
  output ttc_pkg::ttc_gain_type gain_o,
  output ttc_pkg::ttc_pins_type pins_o
);
  import ttc_pkg::*;

  logic [7:0] osc_q;
  logic [7:0] pump_q;
  logic [7:0] conv_q;
  logic [7:0] coup_q;
  logic [7:0] stage_q;
  logic cal_sample_q;
  logic [1:0] rot_pos_q;
  logic ack_q;
  logic [31:0] rdata_q;
  ttc_analog_type analog_d;
  ttc_analog_type analog_q;
  ttc_gain_type gain_d;
  ttc_gain_type gain_q;
  ttc_pins_type pins_d;
  ttc_pins_type pins_q;
  logic vga_ovr_q;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] rd_d;
  logic tm_conn;

  // Next input rotation position for each sequence mode.
  function automatic logic [1:0] next_rot(input logic [1:0] mode,
                                          input logic [1:0] pos);
    logic [1:0] n;
    n = 2'h0;
    case (mode)
      2'h0: n = pos + 2'h1;
      2'h1: begin
        case (pos)
          2'h0: n = 2'h2;
          2'h2: n = 2'h3;
          2'h3: n = 2'h1;
          default: n = 2'h0;
        endcase
      end
      2'h2: n = 2'h0;
      default: n = (pos == 2'h0) ? 2'h2 : 2'h0;
    endcase
    return n;
  endfunction

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[9:2];

  // The answer comes one cycle after the request; unmapped reads give zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_comb begin
    rd_d = 8'h00;
    case (idx)
      TTC_IDX_OSC_CAL: rd_d = osc_q;
      TTC_IDX_PUMP_MIX: rd_d = pump_q;
      TTC_IDX_CONV_SYN: rd_d = conv_q;
      TTC_IDX_COUPLER: rd_d = coup_q;
      TTC_IDX_STAGE: rd_d = stage_q;
      TTC_IDX_CAL_STATUS: rd_d = {6'h00, osc_current_comparator_i,
                                  cal_sample_q};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      rdata_q <= {24'h00_0000, rd_d};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Register writes; reserved bits are dropped so they read back as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_q <= TTC_RST_OSC_CAL;
      pump_q <= TTC_RST_PUMP_MIX;
      conv_q <= TTC_RST_CONV_SYN;
      coup_q <= TTC_RST_COUPLER;
      stage_q <= TTC_RST_STAGE;
    end else if (wr) begin
      case (idx)
        TTC_IDX_OSC_CAL: osc_q <= wb_dat_i[7:0];
        TTC_IDX_PUMP_MIX: pump_q <= wb_dat_i[7:0];
        TTC_IDX_CONV_SYN: conv_q <= wb_dat_i[7:0];
        TTC_IDX_COUPLER: coup_q <= wb_dat_i[7:0] & TTC_COUPLER_MASK;
        TTC_IDX_STAGE: stage_q <= wb_dat_i[7:0] & TTC_STAGE_MASK;
        default: ;
      endcase
    end
  end

  // In hand mode a falling force bit samples the current comparator.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_sample_q <= 1'b0;
    end else if (wr && idx == TTC_IDX_OSC_CAL && osc_q[TTC_OSC_HAND_BIT]
                 && osc_q[TTC_OSC_FORCE_BIT]
                 && !wb_dat_i[TTC_OSC_FORCE_BIT]) begin
      cal_sample_q <= osc_current_comparator_i;
    end
  end

  // Converter input rotation takes its next position on each converter step; mode 2 holds position zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rot_pos_q <= 2'h0;
    end else if (adc_step_i) begin
      rot_pos_q <= next_rot(conv_q[TTC_ROT_LSB +: 2], rot_pos_q);
    end
  end

  assign tm_conn = pump_q[TTC_TM_FILT_BIT] || pump_q[TTC_TM_CONV_BIT];

  always_comb begin
    analog_d = '0;
    if (osc_q[TTC_OSC_FORCE_BIT] && !osc_q[TTC_OSC_HAND_BIT]) begin
      analog_d.osc_current = osc_q[TTC_OSC_VALUE_LSB +: 6];
    end else begin
      analog_d.osc_current = osc_current_cal_i;
    end
    analog_d.osc_cal_strobe = osc_q[TTC_OSC_HAND_BIT]
                              && osc_q[TTC_OSC_FORCE_BIT];
    analog_d.pump_normal_off = pump_q[TTC_PUMP_OFF_BIT];
    analog_d.pump_force_up = pump_q[TTC_PUMP_UP_BIT];
    analog_d.pump_force_down = pump_q[TTC_PUMP_DN_BIT];
    analog_d.mixer_dc_force_en = pump_q[TTC_MIX_EN_BIT];
    if (pump_q[TTC_MIX_EN_BIT]) begin
      analog_d.mixer_i_pos = pump_q[TTC_MIX_POL_LSB + 1];
      analog_d.mixer_q_pos = pump_q[TTC_MIX_POL_LSB];
    end
    analog_d.testmod_to_filter = pump_q[TTC_TM_FILT_BIT];
    analog_d.testmod_to_converter = pump_q[TTC_TM_CONV_BIT];
    if (tm_conn) begin
      analog_d.testmod_powerdown = interface_ctrl_i[TTC_IF_PD_BIT];
      analog_d.testmod_mode = interface_ctrl_i[2:0];
    end else begin
      analog_d.testmod_powerdown = 1'b1;
      analog_d.testmod_mode = {1'b1, interface_ctrl_i[1:0]};
    end
    analog_d.freq_comp_en = conv_q[TTC_FCOMP_BIT];
    analog_d.sigma_delta_dither_en = conv_q[TTC_DITHER_BIT];
    analog_d.integrator_chop_off = conv_q[TTC_CHOP_BIT];
    analog_d.mismatch_shaping_off = conv_q[TTC_SHAPE_BIT];
    analog_d.common_mode_rotation_off = conv_q[TTC_VCM_BIT];
    analog_d.adc_rotate_pos = rot_pos_q;
  end

  always_comb begin
    if (coup_q[TTC_VGA_OVR_BIT]) begin
      gain_d.first_coupler_force = coup_q[TTC_AC1_BIT];
      gain_d.second_coupler_force = coup_q[TTC_AC2_LSB +: 2];
      gain_d.gain_stage_one_force = stage_q[TTC_STG1_LSB +: 2];
      gain_d.gain_stage_two_force = stage_q[TTC_STG2_LSB +: 2];
      gain_d.gain_stage_three_force = stage_q[TTC_STG3_LSB +: 2];
    end else begin
      gain_d = gain_normal_i;
    end
  end

  always_comb begin
    if (conv_q[TTC_ADC_OUT_BIT]) begin
      pins_d.lock_pin = adc_sample_i;
      pins_d.serial_data_pin = adc_sample_i;
      pins_d.serial_data_pin_oe = 1'b1;
      pins_d.serial_clock_pin = adc_sample_clk_i;
    end else begin
      pins_d = pins_normal_i;
    end
  end

  // Outputs track their sources through reset as well, so that they already
  // show the reset values of the registers when reset is released.
  always_ff @(posedge clk_i) begin
    analog_q <= analog_d;
    gain_q <= gain_d;
    pins_q <= pins_d;
    vga_ovr_q <= coup_q[TTC_VGA_OVR_BIT];
  end

  assign analog_o = analog_q;
  assign gain_o = gain_q;
  assign pins_o = pins_q;
  assign vga_override_o = vga_ovr_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_after_req_a: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  write_readback_a: assert property (
    wr && idx == TTC_IDX_PUMP_MIX |=> pump_q == $past(wb_dat_i[7:0]))
    else $error("pump register did not take write");
  osc_force_a: assert property (
    osc_q[TTC_OSC_FORCE_BIT] && !osc_q[TTC_OSC_HAND_BIT]
    |=> analog_o.osc_current == $past(osc_q[5:0]))
    else $error("forced current not applied");
  osc_cal_use_a: assert property (
    !osc_q[TTC_OSC_FORCE_BIT]
    |=> analog_o.osc_current == $past(osc_current_cal_i))
    else $error("calibrated current not applied");
  hand_sample_a: assert property (
    wr && idx == TTC_IDX_OSC_CAL && osc_q[7] && osc_q[6] && !wb_dat_i[6]
    |=> cal_sample_q == $past(osc_current_comparator_i))
    else $error("comparator not sampled on falling strobe");
  testmod_idle_a: assert property (
    !tm_conn
    |=> analog_o.testmod_powerdown && analog_o.testmod_mode[2])
    else $error("idle test module not held off");
  testmod_live_a: assert property (
    tm_conn
    |=> analog_o.testmod_powerdown == $past(interface_ctrl_i[3]))
    else $error("test module powerdown not from interface");
  mixer_pol_a: assert property (
    pump_q[2] |=> {analog_o.mixer_i_pos, analog_o.mixer_q_pos}
                  == $past(pump_q[4:3]))
    else $error("mixer polarity wrong");
  rot_hold_a: assert property (
    conv_q[1:0] == 2'h2 && adc_step_i |=> rot_pos_q == 2'h0)
    else $error("fixed rotation left position zero");
  adc_pins_a: assert property (
    conv_q[5] |=> pins_o.serial_clock_pin == $past(adc_sample_clk_i))
    else $error("converter clock not on clock pin");
  gain_gate_a: assert property (
    coup_q[3] |=> gain_o.second_coupler_force == $past(coup_q[1:0]))
    else $error("coupler override not applied");
  reserved_zero_a: assert property (
    coup_q[7:4] == 4'h0 && stage_q[7:6] == 2'h0)
    else $error("reserved bits stored");

  // Field by field checks of the registered controls and the bus.
  reset_osc_a: assert property (
    $fell(rst_i) |-> osc_q == TTC_RST_OSC_CAL)
    else $error("oscillator register reset value wrong");
  reset_pump_a: assert property (
    $fell(rst_i) |-> pump_q == TTC_RST_PUMP_MIX)
    else $error("pump register reset value wrong");
  reset_conv_a: assert property (
    $fell(rst_i) |-> conv_q == TTC_RST_CONV_SYN)
    else $error("converter register reset value wrong");
  pump_off_a: assert property (
    !rst_i |=> analog_o.pump_normal_off == $past(pump_q[TTC_PUMP_OFF_BIT]))
    else $error("pump disable bit not applied");
  pump_up_a: assert property (
    !rst_i |=> analog_o.pump_force_up == $past(pump_q[TTC_PUMP_UP_BIT]))
    else $error("pump up force not applied");
  pump_down_a: assert property (
    !rst_i |=> analog_o.pump_force_down == $past(pump_q[TTC_PUMP_DN_BIT]))
    else $error("pump down force not applied");
  mixer_en_a: assert property (
    !rst_i |=> analog_o.mixer_dc_force_en == $past(pump_q[TTC_MIX_EN_BIT]))
    else $error("mixer forcing enable not applied");
  mixer_off_a: assert property (
    !pump_q[TTC_MIX_EN_BIT]
    |=> !analog_o.mixer_i_pos && !analog_o.mixer_q_pos)
    else $error("mixer polarity driven while forcing off");
  testmod_route_a: assert property (
    !rst_i |=> {analog_o.testmod_to_filter, analog_o.testmod_to_converter}
               == $past(pump_q[1:0]))
    else $error("test module routing not applied");
  testmod_mode_a: assert property (
    tm_conn |=> analog_o.testmod_mode == $past(interface_ctrl_i[2:0]))
    else $error("test module mode not from interface");
  fcomp_a: assert property (
    !rst_i |=> analog_o.freq_comp_en == $past(conv_q[TTC_FCOMP_BIT]))
    else $error("frequency comparator enable not applied");
  dither_a: assert property (
    !rst_i
    |=> analog_o.sigma_delta_dither_en == $past(conv_q[TTC_DITHER_BIT]))
    else $error("dither enable not applied");
  adc_feature_a: assert property (
    !rst_i |=> {analog_o.integrator_chop_off, analog_o.mismatch_shaping_off,
               analog_o.common_mode_rotation_off} == $past(conv_q[4:2]))
    else $error("converter feature disables not applied");
  adc_data_pin_a: assert property (
    conv_q[TTC_ADC_OUT_BIT] |=> pins_o.serial_data_pin_oe
    && pins_o.serial_data_pin == $past(adc_sample_i)
    && pins_o.lock_pin == $past(adc_sample_i))
    else $error("converter samples not on data pins");
  first_coupler_a: assert property (
    coup_q[TTC_VGA_OVR_BIT]
    |=> gain_o.first_coupler_force == $past(coup_q[TTC_AC1_BIT]))
    else $error("first coupler override not applied");
  stage_force_a: assert property (
    coup_q[TTC_VGA_OVR_BIT] |=> {gain_o.gain_stage_one_force,
    gain_o.gain_stage_two_force, gain_o.gain_stage_three_force}
    == $past(stage_q[5:0]))
    else $error("stage overrides not applied");
  gain_normal_a: assert property (
    !coup_q[TTC_VGA_OVR_BIT] |=> gain_o == $past(gain_normal_i))
    else $error("normal gain not passed through");
  strobe_a: assert property (
    !rst_i |=> analog_o.osc_cal_strobe == $past(osc_q[7] && osc_q[6]))
    else $error("calibration strobe not from force bit");
  hand_current_a: assert property (
    osc_q[TTC_OSC_HAND_BIT]
    |=> analog_o.osc_current == $past(osc_current_cal_i))
    else $error("hand mode did not keep calibrated current");
  rot_step_a: assert property (
    conv_q[1:0] == 2'h0 && adc_step_i
    |=> rot_pos_q == $past(rot_pos_q) + 2'h1)
    else $error("rotation did not count up");
  status_read_a: assert property (
    req && !wb_we_i && idx == TTC_IDX_CAL_STATUS
    |=> wb_dat_o[1] == $past(osc_current_comparator_i))
    else $error("live comparator not read back");
  unmapped_read_a: assert property (
    req && !wb_we_i && idx > TTC_IDX_CAL_STATUS
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  read_upper_a: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  sel_drop_a: assert property (
    req && wb_we_i && !wb_sel_i[0] |=> $stable(stage_q) && $stable(pump_q))
    else $error("write without byte select stored");

  hand_cal_c: cover property (analog_o.osc_cal_strobe ##1 !osc_q[6]);
  adc_out_c: cover property (conv_q[5] && adc_step_i);
  vga_ovr_c: cover property (
    vga_override_o && gain_o.gain_stage_one_force != 0);
  testmod_c: cover property (tm_conn && !interface_ctrl_i[3]);
  rot_seq_c: cover property (conv_q[1:0] == 2'h1 && adc_step_i);

endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ttc_pkg::*;
  localparam logic [1:0] ROT_MODE [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
  localparam logic [7:0] ROT_EXP [4] = '{8'h00, 8'h39, 8'h1E, 8'h22};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [5:0] osc_current_cal_i = 6'h2D;
  logic osc_current_comparator_i = 1'b0;
  logic [3:0] interface_ctrl_i = 4'h0;
  logic adc_sample_i = 1'b0;
  logic adc_sample_clk_i = 1'b0;
  logic adc_step_i = 1'b0;
  logic [8:0] gain_normal_i = 9'h000;
  ttc_pins_type pins_normal_i = 4'h0;
  ttc_analog_type a;
  logic vga_override_o;
  ttc_gain_type gn;
  ttc_pins_type pn;
  int failures = 0;
  int n_checks = 0;
  logic [31:0] rd_exp_q [$];
  logic [31:0] seed = 32'h0000_b6b7;

  ttc_test_bank i_ttc_test_bank (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .osc_current_cal_i(osc_current_cal_i),
    .osc_current_comparator_i(osc_current_comparator_i),
    .interface_ctrl_i(interface_ctrl_i), .adc_sample_i(adc_sample_i),
    .adc_sample_clk_i(adc_sample_clk_i), .adc_step_i(adc_step_i),
    .gain_normal_i(gain_normal_i), .pins_normal_i(pins_normal_i),
    .analog_o(a), .vga_override_o(vga_override_o), .gain_o(gn), .pins_o(pn)
  );

  always #4 clk_i = ~clk_i;

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read data is judged at the ack edge, oldest expectation first.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_exp_q.size() > 0) begin
      chk(wb_dat_o, rd_exp_q.pop_front());
    end
  end

  task automatic wb(input logic we, input logic [7:0] idx,
                    input logic [7:0] d, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {22'h00_0000, idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'h1);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    rd_exp_q.push_back({24'h00_0000, exp});
    wb(1'b0, idx, 8'h00, 4'h1);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic conclude();
    if (rd_exp_q.size() != 0) failures++;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    conclude();
  end

  initial begin
    logic [31:0] d;
    logic [7:0] c8;
    logic [7:0] msk;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(TTC_IDX_OSC_CAL, TTC_RST_OSC_CAL);
    rd(TTC_IDX_PUMP_MIX, 8'h00);
    rd(TTC_IDX_CONV_SYN, 8'h40);
    rd(TTC_IDX_COUPLER, 8'h00);
    rd(TTC_IDX_STAGE, 8'h00);
    tick(2);
    chk(32'({a.testmod_powerdown, a.testmod_mode[2]}), 32'h3);
    for (int i = 0; i < 5; i++) begin
      d = rnd();
      msk = (i < 3) ? 8'hFF : ((i == 3) ? TTC_COUPLER_MASK : TTC_STAGE_MASK);
      wr(8'(8'h23 + i), d[7:0]);
      rd(8'(8'h23 + i), d[7:0] & msk);
    end
    wr(TTC_IDX_STAGE, 8'h2A);
    wb(1'b1, TTC_IDX_STAGE, 8'h15, 4'h0);
    rd(TTC_IDX_STAGE, 8'h2A);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    // Forced against calibrated oscillator current.
    d = rnd();
    wr(TTC_IDX_OSC_CAL, {2'b01, d[5:0]});
    tick(2);
    chk(32'(a.osc_current), 32'(d[5:0]));
    wr(TTC_IDX_OSC_CAL, {2'b00, d[5:0]});
    tick(2);
    chk(32'(a.osc_current), 32'(osc_current_cal_i));
    // Hand calibration samples the comparator on a falling force bit.
    osc_current_comparator_i <= 1'b1;
    wr(TTC_IDX_OSC_CAL, 8'hC0);
    tick(2);
    chk(32'({a.osc_cal_strobe, a.osc_current}),
        32'({1'b1, osc_current_cal_i}));
    wr(TTC_IDX_OSC_CAL, 8'h80);
    rd(TTC_IDX_CAL_STATUS, 8'h03);
    osc_current_comparator_i <= 1'b0;
    wr(TTC_IDX_OSC_CAL, 8'hC0);
    wr(TTC_IDX_OSC_CAL, 8'h80);
    osc_current_comparator_i <= 1'b1;
    tick(2);
    rd(TTC_IDX_CAL_STATUS, 8'h02);
    for (int p = 0; p < 4; p++) begin
      d = rnd();
      wr(TTC_IDX_PUMP_MIX, {d[7:5], 2'(p), 3'b100});
      tick(2);
      chk(32'({a.pump_normal_off, a.pump_force_up, a.pump_force_down}),
          32'(d[7:5]));
      chk(32'({a.mixer_dc_force_en, a.mixer_i_pos, a.mixer_q_pos}),
          32'({1'b1, 2'(p)}));
    end
    wr(TTC_IDX_PUMP_MIX, 8'h18);
    tick(2);
    chk(32'({a.mixer_dc_force_en, a.mixer_i_pos, a.mixer_q_pos}), 0);
    for (int c = 0; c < 4; c++) begin
      d = rnd();
      wr(TTC_IDX_PUMP_MIX, 8'(c));
      interface_ctrl_i <= d[3:0];
      tick(2);
      chk(32'({a.testmod_to_filter, a.testmod_to_converter}), c);
      chk(32'({a.testmod_powerdown, a.testmod_mode}),
          32'((c != 0) ? d[3:0] : {2'b11, d[1:0]}));
    end
    for (int k = 0; k < 6; k++) begin
      d = rnd();
      c8 = {d[7:6], k[0], d[4:0]};
      adc_sample_i <= d[8];
      adc_sample_clk_i <= d[9];
      pins_normal_i <= d[13:10];
      wr(TTC_IDX_CONV_SYN, c8);
      tick(2);
      chk(32'({a.freq_comp_en, a.sigma_delta_dither_en, a.integrator_chop_off,
          a.mismatch_shaping_off, a.common_mode_rotation_off}),
          32'({c8[7:6], c8[4:2]}));
      chk(32'(pn), 32'(k[0] ? {d[8], d[8], 1'b1, d[9]} : d[13:10]));
    end
    for (int m = 0; m < 4; m++) begin
      wr(TTC_IDX_CONV_SYN, {6'h10, ROT_MODE[m]});
      for (int k = 0; k < 4; k++) begin
        adc_step_i <= 1'b1;
        @(posedge clk_i);
        adc_step_i <= 1'b0;
        tick(2);
        chk(32'(a.adc_rotate_pos), 32'(ROT_EXP[m][2*k+:2]));
      end
    end
    for (int g = 0; g < 4; g++) begin
      d = rnd();
      gain_normal_i <= d[24:16];
      wr(TTC_IDX_COUPLER, {4'h0, g[0], d[2:0]});
      wr(TTC_IDX_STAGE, {2'b00, d[8:3]});
      tick(2);
      chk(32'(vga_override_o), 32'(g[0]));
      chk(32'(gn),
          32'(g[0] ? {d[2:0], d[8:3]} : d[24:16]));
    end
    conclude();
  end
endmodule
`default_nettype wire
